// >>> logic/thm_monitor.sv
// thermistor supervision, power-good pin mux, apb register slave and serial target.
// assumes the adc delivers codes on pclk; comparator levels, button and bus pins are async.

// ============================================================================
// What this block does
// - default mode: pin low only while adapter is valid, above sleep margin, below ovp
// - select 01: pin follows the button input level
// - select 1x: pin low when software level is 0, floating when 1
// - with adapter present, bias and sample sensor 25 ms every 225 ms, always
// - thermal control modes: four-threshold, hot/cold only, or off
// - hot or cold region suspends charging and the safety timer
// - cool region scales fast-charge current; code 111 gives one eighth
// - scaled current rounds down to whole current steps
// - warm region applies the programmed regulation voltage drop
// - any thermal event pulses the alert line 128 us in every mode
// - fault bits stay set until read by the host
// - each crossing of hot, warm, cool or cold alerts; thresholds programmable
// - above the open-sensor level charging is off
// - thresholds reset to cold 0.585, cool 0.514, warm 0.265, hot 0.185 V
// - thresholds compare against the top eight bits of the adc code
// - aux input biased like the sensor and readable in the adc slot
// - serial port is target only, same protocol at 100 and 400 kbps
// - serial target answers address 0x6B only
// - address match acknowledged by holding data low through ninth clock
// - register contents kept while supply is up; only reset clears them, except fault bits, which a host read clears
// - reading an unmapped address returns ff
module thm_monitor
  import thm_pkg::*;
#(
  parameter int SAMPLE_WIN_CYC    = THM_SAMPLE_WIN_CYC,
  parameter int SAMPLE_PERIOD_CYC = THM_SAMPLE_PERIOD_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] ts_adc_code,
  input  wire logic        ts_adc_valid,
  input  wire logic [15:0] aux_adc_code,
  input  wire logic        aux_adc_valid,
  input  wire logic        vin_uvlo_ok,
  input  wire logic        vin_sleep_ok,
  input  wire logic        vin_ovp_ok,
  input  wire logic        button_in,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             power_good_o,
  output logic             power_good_oe,
  output logic             ts_bias_en,
  output logic             aux_bias_en,
  output logic             charge_enable,
  output logic             safety_timer_pause,
  output logic      [7:0]  charge_current_code,
  output logic      [3:0]  vreg_drop_code,
  output logic             host_alert_n
);

  thm_state_s st;
  thm_state_s next_st;

  logic [3:0]  apb_idx;
  logic        apb_map;
  logic        apb_wr;
  logic        i2c_wr;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [7:0]  wr_dat;
  logic [4:0]  clr;
  logic [4:0]  rg_new;
  logic        sample_done;
  logic        susp;
  logic        jeita;
  logic [11:0] prod;
  logic [7:0]  v8;
  logic        scl_rise;
  logic        scl_fall;
  logic        i2c_start;
  logic        i2c_stop;
  logic [15:0] rd_val;

  function automatic logic [15:0] rd_reg(input logic [3:0] idx, input thm_state_s s);
    logic [15:0] r;
    r = THM_UNMAPPED;
    unique case (idx)
      THM_REG_CTRL:   r = {9'h000, s.adc_slot, s.aux_en, s.tmode, s.pin_level, s.pin_sel};
      THM_REG_COLD:   r = {8'h00, s.th_cold};
      THM_REG_COOL:   r = {8'h00, s.th_cool};
      THM_REG_WARM:   r = {8'h00, s.th_warm};
      THM_REG_HOT:    r = {8'h00, s.th_hot};
      THM_REG_OPEN:   r = {8'h00, s.th_open};
      THM_REG_CHGCTL: r = {8'h00, s.vreg_drop, 1'b0, s.cool_scale};
      THM_REG_FAST_CHARGE_CURRENT:   r = {8'h00, s.fast_charge_current};
      THM_REG_STATUS: r = {11'h000, s.region};
      THM_REG_FAULT:  r = {11'h000, s.fault};
      // the adc slot shows either the sensor or the aux result
      THM_REG_ADC:    r = s.adc_slot ? s.aux_code : s.ts_code;
      default:        r = THM_UNMAPPED;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // next-state logic
  always_comb begin
    next_st     = st;
    apb_idx     = paddr[5:2];
    apb_map     = (paddr[7:6] == 2'h0) && (apb_idx < THM_REG_COUNT);
    apb_wr      = psel && penable && st.pready && pwrite && apb_map;
    i2c_wr      = 1'b0;
    clr         = 5'h00;
    rd_val      = 16'h0000;
    scl_rise    = st.scl_sy[1] && !st.scl_d;
    scl_fall    = !st.scl_sy[1] && st.scl_d;
    i2c_start   = st.scl_sy[1] && st.scl_d && st.sda_d && !st.sda_sy[1];
    i2c_stop    = st.scl_sy[1] && st.scl_d && !st.sda_d && st.sda_sy[1];

    // two-flop synchronisers; only stage 1 is read by logic
    next_st.uv_sy  = {st.uv_sy[0], vin_uvlo_ok};
    next_st.slp_sy = {st.slp_sy[0], vin_sleep_ok};
    next_st.ov_sy  = {st.ov_sy[0], vin_ovp_ok};
    next_st.btn_sy = {st.btn_sy[0], button_in};
    next_st.scl_sy = {st.scl_sy[0], scl_i};
    next_st.sda_sy = {st.sda_sy[0], sda_i};
    next_st.scl_d  = st.scl_sy[1];
    next_st.sda_d  = st.sda_sy[1];

    // ========================================================================
    // power-good pin mux
    unique casez (st.pin_sel)
      2'b00: next_st.pg_oe = st.uv_sy[1] && st.slp_sy[1] && st.ov_sy[1];
      2'b01: next_st.pg_oe = !st.btn_sy[1];
      2'b1?: next_st.pg_oe = !st.pin_level;
      default: next_st.pg_oe = 1'b0;
    endcase

    // ========================================================================
    // apb slave: answers one cycle after setup, read data captured at setup
    next_st.pready = psel && !penable && !st.pready;
    if (psel && !penable && !st.pready) begin
      next_st.prdata = {16'h0000, apb_map ? rd_reg(apb_idx, st) : THM_UNMAPPED};
    end
    // clear only the fault bits that were actually returned
    if (psel && penable && st.pready && !pwrite && apb_map && apb_idx == THM_REG_FAULT) begin
      clr = st.prdata[4:0];
    end

    // ========================================================================
    // serial target; no clock stretching, so scl is only ever an input
    if (i2c_start) begin
      next_st.i2c_st  = THM_I2C_ADDR;
      next_st.i2c_cnt = 4'h0;
      next_st.i2c_ack = 1'b0;
      next_st.sda_oe  = 1'b0;
    end else if (i2c_stop) begin
      next_st.i2c_st  = THM_I2C_IDLE;
      next_st.i2c_ack = 1'b0;
      next_st.sda_oe  = 1'b0;
    end else if (scl_rise) begin
      if (st.i2c_ack) begin
        if (st.i2c_st == THM_I2C_RDAT && !st.sda_oe && st.sda_sy[1]) begin
          next_st.i2c_st = THM_I2C_IDLE;
        end
      end else if (st.i2c_st != THM_I2C_IDLE && st.i2c_st != THM_I2C_RDAT) begin
        next_st.i2c_sh  = {st.i2c_sh[6:0], st.sda_sy[1]};
        next_st.i2c_cnt = st.i2c_cnt + 4'h1;
      end
    end else if (scl_fall) begin
      if (st.i2c_ack) begin
        next_st.i2c_ack = 1'b0;
        next_st.sda_oe  = 1'b0;
        next_st.i2c_cnt = 4'h0;
        if (st.i2c_st == THM_I2C_RDAT) begin
          rd_val = (st.i2c_ptr < {4'h0, THM_REG_COUNT}) ?
                   rd_reg(st.i2c_ptr[3:0], st) : THM_UNMAPPED;
          next_st.i2c_sh  = rd_val[7:0];
          next_st.sda_oe  = !rd_val[7];
          next_st.i2c_ptr = st.i2c_ptr + 8'h01;
          if (st.i2c_ptr == {4'h0, THM_REG_FAULT}) begin
            clr = clr | rd_val[4:0];
          end
        end
      end else if (st.i2c_st == THM_I2C_RDAT) begin
        if (st.i2c_cnt == 4'h7) begin
          next_st.i2c_ack = 1'b1;
          next_st.sda_oe  = 1'b0;
        end else begin
          next_st.i2c_sh  = {st.i2c_sh[6:0], 1'b0};
          next_st.sda_oe  = !st.i2c_sh[6];
          next_st.i2c_cnt = st.i2c_cnt + 4'h1;
        end
      end else if (st.i2c_cnt == 4'h8) begin
        unique case (st.i2c_st)
          THM_I2C_ADDR: begin
            if (st.i2c_sh[7:1] == THM_I2C_ADDR7) begin
              next_st.i2c_ack = 1'b1;
              next_st.sda_oe  = 1'b1;
              next_st.i2c_st  = st.i2c_sh[0] ? THM_I2C_RDAT : THM_I2C_PTR;
            end else begin
              next_st.i2c_st  = THM_I2C_IDLE;
            end
          end
          THM_I2C_PTR: begin
            next_st.i2c_ptr = st.i2c_sh;
            next_st.i2c_st  = THM_I2C_WDAT;
            next_st.i2c_ack = 1'b1;
            next_st.sda_oe  = 1'b1;
          end
          THM_I2C_WDAT: begin
            i2c_wr          = 1'b1;
            next_st.i2c_ptr = st.i2c_ptr + 8'h01;
            next_st.i2c_ack = 1'b1;
            next_st.sda_oe  = 1'b1;
          end
          default: next_st.i2c_st = THM_I2C_IDLE;
        endcase
      end
    end

    // ========================================================================
    // register writes; apb wins if both ports write in the same cycle
    wr_en  = apb_wr || (i2c_wr && st.i2c_ptr < {4'h0, THM_REG_COUNT});
    wr_idx = apb_wr ? apb_idx : st.i2c_ptr[3:0];
    wr_dat = apb_wr ? pwdata[7:0] : st.i2c_sh;
    if (wr_en) begin
      unique case (wr_idx)
        THM_REG_CTRL: begin
          next_st.pin_sel   = wr_dat[1:0];
          next_st.pin_level = wr_dat[2];
          next_st.tmode     = wr_dat[4:3];
          next_st.aux_en    = wr_dat[5];
          next_st.adc_slot  = wr_dat[6];
        end
        THM_REG_COLD:   next_st.th_cold = wr_dat;
        THM_REG_COOL:   next_st.th_cool = wr_dat;
        THM_REG_WARM:   next_st.th_warm = wr_dat;
        THM_REG_HOT:    next_st.th_hot  = wr_dat;
        THM_REG_OPEN:   next_st.th_open = wr_dat;
        THM_REG_CHGCTL: begin
          next_st.cool_scale = wr_dat[2:0];
          next_st.vreg_drop  = wr_dat[7:4];
        end
        THM_REG_FAST_CHARGE_CURRENT:   next_st.fast_charge_current = wr_dat;
        default: ;
      endcase
    end

    // ========================================================================
    // sampling window; bias runs only while the adapter is present
    if (!st.uv_sy[1]) begin
      next_st.win_cnt = 23'h00_0000;
      next_st.bias    = 1'b0;
    end else begin
      next_st.win_cnt = (st.win_cnt == 23'(SAMPLE_PERIOD_CYC - 1)) ? 23'h00_0000 :
                        st.win_cnt + 23'h00_0001;
      next_st.bias    = next_st.win_cnt < 23'(SAMPLE_WIN_CYC);
    end
    if (st.bias && ts_adc_valid) begin
      next_st.ts_code = ts_adc_code;
    end
    if (st.bias && st.aux_en && aux_adc_valid) begin
      next_st.aux_code = aux_adc_code;
    end

    // regions are judged once per window, at its last cycle
    sample_done = st.bias && (st.win_cnt == 23'(SAMPLE_WIN_CYC - 1));
    v8 = st.ts_code[15:8];
    rg_new[THM_RG_OPEN] = v8 > st.th_open;
    rg_new[THM_RG_COLD] = v8 > st.th_cold;
    rg_new[THM_RG_COOL] = (v8 > st.th_cool) && (v8 <= st.th_cold);
    rg_new[THM_RG_WARM] = (v8 < st.th_warm) && (v8 >= st.th_hot);
    rg_new[THM_RG_HOT]  = v8 < st.th_hot;

    // a new fault bit is set after the clear so the set wins
    next_st.fault = st.fault & ~clr;
    if (sample_done) begin
      next_st.region = rg_new;
      next_st.fault  = next_st.fault | (rg_new & ~st.region);
    end

    // alert pulse on every change of region, whatever the mode
    if (sample_done && rg_new != st.region) begin
      next_st.alert_cnt = 12'(THM_ALERT_CYC - 1);
      next_st.alert_n   = 1'b0;
    end else if (st.alert_cnt != 12'h000) begin
      next_st.alert_cnt = st.alert_cnt - 12'h001;
    end else begin
      next_st.alert_n   = 1'b1;
    end

    // ========================================================================
    // charge control
    jeita = st.tmode == THM_MODE_JEITA;
    susp  = (jeita || st.tmode == THM_MODE_HC) &&
            (st.region[THM_RG_HOT] || st.region[THM_RG_COLD]);
    next_st.charge_en   = st.uv_sy[1] && !susp && !st.region[THM_RG_OPEN];
    next_st.timer_pause = susp || st.region[THM_RG_OPEN];
    // fraction is (8 - code) / 8; the shift drops the remainder
    prod = 12'(st.fast_charge_current) * 12'(4'h8 - {1'b0, st.cool_scale});
    next_st.chg_code  = (jeita && st.region[THM_RG_COOL]) ? prod[10:3] : st.fast_charge_current;
    next_st.vreg_code = (jeita && st.region[THM_RG_WARM]) ? st.vreg_drop : 4'h0;
  end

  // ==========================================================================
  // state register; reset is the supply-loss event, nothing else clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.pin_sel    <= THM_PINSEL_RST;
      st.tmode      <= THM_MODE_JEITA;
      st.th_cold    <= THM_COLD_RST;
      st.th_cool    <= THM_COOL_RST;
      st.th_warm    <= THM_WARM_RST;
      st.th_hot     <= THM_HOT_RST;
      st.th_open    <= THM_OPEN_RST;
      st.cool_scale <= THM_SCALE_RST;
      st.vreg_drop  <= THM_VDROP_RST;
      st.fast_charge_current       <= THM_FAST_CHARGE_CURRENT_RST;
      st.chg_code   <= THM_FAST_CHARGE_CURRENT_RST;
      st.alert_n    <= 1'b1;
      st.i2c_st     <= THM_I2C_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = 1'b0;
  assign sda_o               = 1'b0;
  assign sda_oe              = st.sda_oe;
  assign power_good_o        = 1'b0;
  assign power_good_oe       = st.pg_oe;
  assign ts_bias_en          = st.bias;
  assign aux_bias_en         = st.bias && st.aux_en;
  assign charge_enable       = st.charge_en;
  assign safety_timer_pause  = st.timer_pause;
  assign charge_current_code = st.chg_code;
  assign vreg_drop_code      = st.vreg_code;
  assign host_alert_n        = st.alert_n;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_setup;
    psel && !penable && !st.pready;
  endsequence

  a_pg_default_mode: assert property ((st.pin_sel == 2'b00) |=>
    power_good_oe == $past(st.uv_sy[1] && st.slp_sy[1] && st.ov_sy[1]))
    else $error("pg default mode wrong");
  a_pg_button_mirror: assert property ((st.pin_sel == 2'b01) |=>
    power_good_oe == !$past(st.btn_sy[1]))
    else $error("pg button mirror wrong");
  a_pg_soft_level: assert property (st.pin_sel[1] |=>
    power_good_oe == !$past(st.pin_level))
    else $error("pg software level wrong");
  // bias is registered from the previous cycle's adapter state, so judge it against that
  a_bias_window: assert property (ts_bias_en |->
    (st.win_cnt < 23'(SAMPLE_WIN_CYC)) && $past(st.uv_sy[1]))
    else $error("bias outside window");
  a_suspend_hotcold: assert property ((st.tmode != THM_MODE_OFF &&
    st.tmode != 2'h3 && (st.region[THM_RG_HOT] || st.region[THM_RG_COLD]))
    |=> !charge_enable && safety_timer_pause)
    else $error("charge not suspended");
  a_open_disable: assert property (st.region[THM_RG_OPEN] |=> !charge_enable)
    else $error("charge on with open sensor");
  a_cool_scale: assert property ((jeita && st.region[THM_RG_COOL] && $stable(st.fast_charge_current)) |=>
    charge_current_code == 8'((12'($past(st.fast_charge_current)) * 12'(4'h8 -
    {1'b0, $past(st.cool_scale)})) >> 3))
    else $error("cool current wrong");
  a_alert_on_cross: assert property ($changed(st.region) |-> !host_alert_n ##1 !host_alert_n)
    else $error("no alert on crossing");
  a_fault_sticky: assert property ((clr == 5'h00) |=>
    (st.fault & $past(st.fault)) == $past(st.fault))
    else $error("fault bit lost without read");
  a_region_hold: assert property (!sample_done |=> $stable(st.region))
    else $error("region changed between samples");
  a_apb_unmapped: assert property ((s_apb_setup and !apb_map) |=>
    pready && prdata == 32'h0000_00FF)
    else $error("unmapped read not ff");

endmodule

// >>> logic/thm_pkg.sv
// constants, register map and state layout of the thermistor monitor block.
// assumes a single 25 MHz clock; all timing counts are derived from it here.
package thm_pkg;

  // ==========================================================================
  // timing
  localparam int THM_CLK_HZ            = 25_000_000;
  localparam int THM_SAMPLE_WIN_MS     = 25;
  localparam int THM_SAMPLE_PERIOD_MS  = 225;
  localparam int THM_ALERT_US          = 128;
  localparam int THM_SAMPLE_WIN_CYC    = THM_SAMPLE_WIN_MS * (THM_CLK_HZ / 1000);
  localparam int THM_SAMPLE_PERIOD_CYC = THM_SAMPLE_PERIOD_MS * (THM_CLK_HZ / 1000);
  localparam int THM_ALERT_CYC         = THM_ALERT_US * (THM_CLK_HZ / 1_000_000);

  // ==========================================================================
  // register indices; byte address is four times the index
  localparam logic [3:0] THM_REG_CTRL    = 4'h0;
  localparam logic [3:0] THM_REG_COLD    = 4'h1;
  localparam logic [3:0] THM_REG_COOL    = 4'h2;
  localparam logic [3:0] THM_REG_WARM    = 4'h3;
  localparam logic [3:0] THM_REG_HOT     = 4'h4;
  localparam logic [3:0] THM_REG_OPEN    = 4'h5;
  localparam logic [3:0] THM_REG_CHGCTL  = 4'h6;
  localparam logic [3:0] THM_REG_FAST_CHARGE_CURRENT    = 4'h7;
  localparam logic [3:0] THM_REG_STATUS  = 4'h8;
  localparam logic [3:0] THM_REG_FAULT   = 4'h9;
  localparam logic [3:0] THM_REG_ADC     = 4'hA;
  localparam logic [3:0] THM_REG_COUNT   = 4'hB;
  localparam logic [15:0] THM_UNMAPPED   = 16'h00FF;

  // region / fault bit positions
  localparam int THM_RG_OPEN = 0;
  localparam int THM_RG_COLD = 1;
  localparam int THM_RG_COOL = 2;
  localparam int THM_RG_WARM = 3;
  localparam int THM_RG_HOT  = 4;

  // thermal control modes
  localparam logic [1:0] THM_MODE_OFF   = 2'h0;
  localparam logic [1:0] THM_MODE_HC    = 2'h1;
  localparam logic [1:0] THM_MODE_JEITA = 2'h2;

  // ==========================================================================
  // reset values; thresholds are 8 msbs of a 1.2 V full-scale code
  localparam logic [7:0] THM_COLD_RST   = 8'h7C;
  localparam logic [7:0] THM_COOL_RST   = 8'h6D;
  localparam logic [7:0] THM_WARM_RST   = 8'h38;
  localparam logic [7:0] THM_HOT_RST    = 8'h27;
  localparam logic [7:0] THM_OPEN_RST   = 8'hC0;
  localparam logic [7:0] THM_FAST_CHARGE_CURRENT_RST   = 8'h0C;
  localparam logic [2:0] THM_SCALE_RST  = 3'h4;
  localparam logic [3:0] THM_VDROP_RST  = 4'h0;
  localparam logic [1:0] THM_PINSEL_RST = 2'h0;

  // serial target address, 7 bit form
  localparam logic [6:0] THM_I2C_ADDR7  = 7'h6B;

  typedef enum logic [2:0] {
    THM_I2C_IDLE = 3'b000,
    THM_I2C_ADDR = 3'b001,
    THM_I2C_PTR  = 3'b010,
    THM_I2C_WDAT = 3'b011,
    THM_I2C_RDAT = 3'b100
  } thm_i2c_e;

  typedef struct packed {
    logic [1:0]  pin_sel;
    logic        pin_level;
    logic [1:0]  tmode;
    logic        aux_en;
    logic        adc_slot;
    logic [7:0]  th_cold;
    logic [7:0]  th_cool;
    logic [7:0]  th_warm;
    logic [7:0]  th_hot;
    logic [7:0]  th_open;
    logic [2:0]  cool_scale;
    logic [3:0]  vreg_drop;
    logic [7:0]  fast_charge_current;
    logic [4:0]  region;
    logic [4:0]  fault;
    logic [15:0] ts_code;
    logic [15:0] aux_code;
    logic [22:0] win_cnt;
    logic        bias;
    logic [11:0] alert_cnt;
    logic        alert_n;
    logic [1:0]  uv_sy;
    logic [1:0]  slp_sy;
    logic [1:0]  ov_sy;
    logic [1:0]  btn_sy;
    logic [1:0]  scl_sy;
    logic [1:0]  sda_sy;
    logic        scl_d;
    logic        sda_d;
    logic        pg_oe;
    logic        charge_en;
    logic        timer_pause;
    logic [7:0]  chg_code;
    logic [3:0]  vreg_code;
    logic [31:0] prdata;
    logic        pready;
    thm_i2c_e    i2c_st;
    logic        i2c_ack;
    logic [3:0]  i2c_cnt;
    logic [7:0]  i2c_sh;
    logic [7:0]  i2c_ptr;
    logic        sda_oe;
  } thm_state_s;

endpackage

// >>> verification/thm_i2c_host.sv
// serial bus host model that faces the thermistor monitor's serial target.
// assumes pull-ups on both lines; the bench resolves sda from all enables.
module thm_i2c_host (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ack;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ==========================================================================
  // bit cells of 320 ns; scl stands high between frames
  task automatic bit_cell(input logic b, output logic s);
    sda_drv = b;
    #80 scl = 1'b1;
    #80 s = sda_line;
    #80 scl = 1'b0;
    #80;
  endtask
  // write one register; ack ends up low only if all three bytes were acked
  task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic [26:0] w;
    logic        s;
    w = {a, 1'b0, 1'b1, p, 1'b1, d, 1'b1};
    ack = 1'b0;
    sda_drv = 1'b0;
    #160 scl = 1'b0;
    #80;
    for (int i = 26; i >= 0; i--) begin
      bit_cell(w[i], s);
      if (i % 9 == 0) ack = ack | s;
    end
    sda_drv = 1'b0;
    #80 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #160;
  endtask
endmodule

// >>> verification/thermistor_monitor_host_port_tb.sv
// apb-driven bench for the thermistor monitor, with a serial host model.
// assumes the design runs with shortened sample window and period.
module thermistor_monitor_host_port_tb;
  import thm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, uv, btn, pready, sda_oe;
  logic        pg_oe, ts_bias, chg_en, tpause, alert_n, scl, sda_drv;
  logic [7:0]  paddr, cur;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ts_code;
  logic [3:0]  vdrop;
  int          failures = 0;
  int          cmp_count = 0;
  int          n;
  wire         sda_line = sda_drv & ~sda_oe;
  thm_monitor #(.SAMPLE_WIN_CYC(20), .SAMPLE_PERIOD_CYC(100)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .ts_adc_code(ts_code), .ts_adc_valid(1'b1), .aux_adc_code(16'h1234),
    .aux_adc_valid(1'b1), .vin_uvlo_ok(uv), .vin_sleep_ok(uv), .vin_ovp_ok(uv),
    .button_in(btn), .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe),
    .power_good_o(), .power_good_oe(pg_oe), .ts_bias_en(ts_bias), .aux_bias_en(),
    .charge_enable(chg_en), .safety_timer_pause(tpause), .charge_current_code(cur),
    .vreg_drop_code(vdrop), .host_alert_n(alert_n));
  thm_i2c_host host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
  // ==========================================================================
  // helpers
  task automatic results();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      failures++;
      results();
    end
  endtask
  task automatic rchk(input logic [3:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask
  // move the sensed code, then let two and a half sample periods pass
  task automatic temp(input logic [15:0] c, input logic e, input logic [7:0] i,
                      input logic [3:0] v);
    ts_code <= c;
    cyc(250);
    chk(alert_n, 1'b0);
    chk(chg_en, e);
    chk(cur, i);
    chk(vdrop, v);
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ts_code = 16'h4000;
    uv = 1'b1;
    btn = 1'b1;
    cyc(2);
    presetn <= 1'b1;
    rchk(THM_REG_COLD, 32'h0000_007C);
    rchk(THM_REG_COOL, 32'h0000_006D);
    rchk(THM_REG_WARM, 32'h0000_0038);
    rchk(THM_REG_HOT, 32'h0000_0027);
    rchk(THM_REG_OPEN, 32'h0000_00C0);
    rchk(4'hC, 32'h0000_00FF);
    chk(pg_oe, 1'b1);
    apb(1'b1, THM_REG_CTRL, 8'h10);
    apb(1'b1, THM_REG_CHGCTL, 8'h57);
    n = 0;
    repeat (100) begin
      @(posedge pclk);
      n += ts_bias;
    end
    chk(n, 20);
    temp(16'h8000, 1'b0, 8'h0C, 4'h0);
    chk(tpause, 1'b1);
    rchk(THM_REG_FAULT, 32'h0000_0002);
    rchk(THM_REG_FAULT, 32'h0000_0000);
    temp(16'h7000, 1'b1, 8'h01, 4'h0);
    temp(16'h3000, 1'b1, 8'h0C, 4'h5);
    temp(16'h2000, 1'b0, 8'h0C, 4'h0);
    temp(16'hD000, 1'b0, 8'h0C, 4'h0);
    rchk(THM_REG_STATUS, 32'h0000_0003);
    // hot/cold-only mode: cool region leaves current unscaled
    apb(1'b1, THM_REG_CTRL, 8'h08);
    temp(16'h7000, 1'b1, 8'h0C, 4'h0);
    // mode off with aux shown in the adc slot: cold no longer suspends
    apb(1'b1, THM_REG_CTRL, 8'h60);
    temp(16'h8000, 1'b1, 8'h0C, 4'h0);
    rchk(THM_REG_ADC, 32'h0000_1234);
    cyc(3300);
    chk(alert_n, 1'b1);
    apb(1'b1, THM_REG_CTRL, 8'h12);
    cyc(4);
    chk(pg_oe, 1'b1);
    apb(1'b1, THM_REG_CTRL, 8'h16);
    cyc(4);
    chk(pg_oe, 1'b0);
    apb(1'b1, THM_REG_CTRL, 8'h11);
    btn <= 1'b0;
    cyc(5);
    chk(pg_oe, 1'b1);
    btn <= 1'b1;
    cyc(5);
    chk(pg_oe, 1'b0);
    apb(1'b1, THM_REG_CTRL, 8'h10);
    uv <= 1'b0;
    cyc(5);
    chk(pg_oe, 1'b0);
    host.xfer(7'h6B, 8'h04, 8'h30);
    chk(host.ack, 1'b0);
    rchk(THM_REG_HOT, 32'h0000_0030);
    host.xfer(7'h6A, 8'h04, 8'h11);
    chk(host.ack, 1'b1);
    rchk(THM_REG_HOT, 32'h0000_0030);
    results();
  end
endmodule
